// >>> core/adc_seq_pkg.sv
// Purpose: shared constants for the converter sequencing block
// Assumes: the oscillator period equals one clk_i period
// Notes: conversion tables are in oscillator periods
// Summary of operation
// - standby or a cleared start or power-on bit halts conversion; analog_en_o drops only with the power-on bit.
// - a result read that meets a result store returns the old value, then the new is stored.
// - a mode or channel write that meets a result store wins; no store and no flag.
// - a channel write never clears the conversion-end flag.
// - a flag seen just after a channel switch may belong to the old channel.
// - a mode or channel write may spoil the result, so software reads it first.
// - the time code selects 288, 240, 192, 144, 120 or 96 periods; others are barred.
// - sampling lasts 40, 32, 24, 20, 16 or 12 periods after a start delay in range.
// - the start delay counts from the end of the enabling bus access.
// - the input is sampled during one eighth to one seventh of each conversion only.
// - clearing the start bit stops the conversion at once.
// - writing mode, channel or power-fail registers restarts a running conversion.
// - a finished conversion stores the result and sets the flag, gated in power-fail mode, unless a mode or channel write or a restart pulse meets it.
package adc_seq_pkg;
  localparam logic [7:0] ADDR_MODE   = 8'h00;
  localparam logic [7:0] ADDR_CHAN   = 8'h04;
  localparam logic [7:0] ADDR_RESULT = 8'h08;
  localparam logic [7:0] ADDR_PFM    = 8'h0c;
  localparam logic [7:0] ADDR_PFT    = 8'h10;
  localparam logic [7:0] ADDR_ISTAT  = 8'h14;
  localparam logic [7:0] ADDR_IMASK  = 8'h18;
  localparam int START_BIT  = 7;
  localparam int PWR_BIT    = 0;
  localparam int TSEL_LSB   = 3;
  localparam int PF_EN_BIT  = 7;
  localparam int PF_CMP_BIT = 6;
  localparam int FLAG_BIT   = 0;
  localparam int BUSY_BIT   = 8;
  localparam int SAMP_BIT   = 9;
  localparam logic [7:0] MODE_WMASK = 8'hb9;
  localparam logic [7:0] PFM_WMASK  = 8'hc0;
  localparam logic [7:0] MODE_RST   = 8'h00;
  localparam logic [7:0] PFM_RST    = 8'h00;
  localparam logic [7:0] PFT_RST    = 8'h00;
  localparam logic [1:0] CHAN_RST   = 2'h0;
  localparam int CNT_W = 9;

  // conversion time per code, zero marks a barred code
  function automatic logic [8:0] conv_cycles(input logic [2:0] code);
    case (code)
      3'h0:    conv_cycles = 9'd288;
      3'h1:    conv_cycles = 9'd240;
      3'h2:    conv_cycles = 9'd192;
      3'h4:    conv_cycles = 9'd144;
      3'h5:    conv_cycles = 9'd120;
      3'h6:    conv_cycles = 9'd96;
      default: conv_cycles = 9'd0;
    endcase
  endfunction : conv_cycles

  function automatic logic [8:0] sample_cycles(input logic [2:0] code);
    case (code)
      3'h0:    sample_cycles = 9'd40;
      3'h1:    sample_cycles = 9'd32;
      3'h2:    sample_cycles = 9'd24;
      3'h4:    sample_cycles = 9'd20;
      3'h5:    sample_cycles = 9'd16;
      3'h6:    sample_cycles = 9'd12;
      default: sample_cycles = 9'd0;
    endcase
  endfunction : sample_cycles

  // start delay, lower end of each allowed range
  function automatic logic [8:0] delay_cycles(input logic [2:0] code);
    case (code)
      3'h0:    delay_cycles = 9'd32;
      3'h1:    delay_cycles = 9'd28;
      3'h2:    delay_cycles = 9'd24;
      3'h4:    delay_cycles = 9'd16;
      3'h5:    delay_cycles = 9'd14;
      3'h6:    delay_cycles = 9'd12;
      default: delay_cycles = 9'd0;
    endcase
  endfunction : delay_cycles

  function automatic logic code_ok(input logic [2:0] code);
    code_ok = (conv_cycles(code) != 9'd0);
  endfunction : code_ok
endpackage : adc_seq_pkg

// >>> core/conv_timer_if.sv
// Purpose: control path between sequencer and conversion timer
// Assumes: both ends on clk_i
// Notes: run is a level, restart and done are one-cycle pulses
`timescale 1ns/1ns
interface conv_timer_if;
  logic       run;
  logic       restart;
  logic [2:0] code;
  logic       sampling;
  logic       busy;
  logic       done;
  modport ctrl (output run, restart, code, input sampling, busy, done);
  modport tmr  (input run, restart, code, output sampling, busy, done);
endinterface : conv_timer_if

// >>> core/conv_timer.sv
// Purpose: start delay, sampling window and conversion time counter
// Assumes: code only changes together with a restart
// Notes: after each done the next conversion samples at once
`timescale 1ns/1ns
module conv_timer (
  input wire logic   clk_i,
  input wire logic   rst_i,
  conv_timer_if.tmr  t
);
  typedef enum logic [1:0] {ph_idle, ph_delay, ph_sample, ph_convert} phase_e;
  phase_e                     ph_reg;
  logic [adc_seq_pkg::CNT_W-1:0] cnt_reg;
  logic                       samp_reg;
  logic                       done_reg;
  logic [8:0]                 samp_len;
  logic [8:0]                 conv_len;
  logic [8:0]                 dly_len;

  assign samp_len = adc_seq_pkg::sample_cycles(t.code);
  assign conv_len = adc_seq_pkg::conv_cycles(t.code);
  assign dly_len  = adc_seq_pkg::delay_cycles(t.code);

  // phase sequencing; counting starts after the access that enabled us
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_reg   <= ph_idle;
      cnt_reg  <= '0;
      samp_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (!t.run) begin
        ph_reg   <= ph_idle;
        samp_reg <= 1'b0;
      end else if (t.restart || ph_reg == ph_idle) begin
        ph_reg   <= ph_delay;
        cnt_reg  <= dly_len - 9'd1;
        samp_reg <= 1'b0;
      end else begin
        case (ph_reg)
          ph_delay: begin
            if (cnt_reg == '0) begin
              ph_reg   <= ph_sample;
              cnt_reg  <= samp_len - 9'd1;
              samp_reg <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - 9'd1;
            end
          end
          ph_sample: begin
            if (cnt_reg == '0) begin
              ph_reg   <= ph_convert;
              cnt_reg  <= conv_len - samp_len - 9'd1;
              samp_reg <= 1'b0;
            end else begin
              cnt_reg <= cnt_reg - 9'd1;
            end
          end
          ph_convert: begin
            if (cnt_reg == '0) begin
              done_reg <= 1'b1;
              ph_reg   <= ph_sample;
              cnt_reg  <= samp_len - 9'd1;
              samp_reg <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg - 9'd1;
            end
          end
          default: ph_reg <= ph_idle;
        endcase
      end
    end
  end

  assign t.sampling = samp_reg;
  assign t.busy     = (ph_reg != ph_idle);
  assign t.done     = done_reg;

  // helper: length of the last sampling window and of the last conversion
  logic [9:0] samp_cnt;
  logic [9:0] conv_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i || !t.run || t.restart) begin
      samp_cnt <= '0;
      conv_cnt <= '0;
    end else begin
      samp_cnt <= samp_reg ? samp_cnt + 10'd1 : 10'd0;
      // a done opens the next window at once, so the count starts over there
      conv_cnt <= (ph_reg == ph_delay) ? 10'd0 :
                  done_reg ? 10'd1 : conv_cnt + 10'd1;
    end
  end

  a_sample_window: assert property (@(posedge clk_i) disable iff (rst_i)
    ($fell(samp_reg) && t.run && !$past(t.restart)) |->
    samp_cnt == {1'b0, $past(samp_len)})
    else $error("sampling window length wrong");

  a_done_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_reg && $past(t.run) && $past(ph_reg) == ph_convert) |->
    conv_cnt == {1'b0, conv_len} - 10'd1 || conv_cnt == {1'b0, conv_len})
    else $error("conversion time wrong");
endmodule : conv_timer

// >>> core/adc_conversion_sequencing.sv
// Purpose: register file and sequencing around a four-channel converter
// Assumes: classic wishbone slave, analog core result valid at done
// Notes: every access answers one cycle after the request
`timescale 1ns/1ns
module adc_conversion_sequencing #(
  parameter int RES_W = 10
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [7:0]       wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             standby_i,
  input  wire logic [RES_W-1:0] conv_data_i,
  output logic      [1:0]       channel_o,
  output logic                  analog_en_o,
  output logic                  sample_o,
  output logic                  irq_o
);
  // the compare takes the top eight bits, so narrower results are refused
  if (RES_W < 8 || RES_W > 16) begin : g_bad_width
    $error("RES_W must be 8 to 16");
  end

  conv_timer_if tif ();

  logic [7:0]       mode_reg;
  logic [1:0]       chan_reg;
  logic [RES_W-1:0] result_reg;
  logic [7:0]       pfm_reg;
  logic [7:0]       pft_reg;
  logic             flag_reg;
  logic             mask_reg;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic             irq_reg;
  logic             wr4_q_reg;

  logic req;
  logic wr;
  logic wr_lo;
  logic wr_mode;
  logic wr_chan;
  logic wr_pf;
  logic rd_result;
  logic supp;
  logic store;
  logic set_flag;
  logic clr_flag;

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction : hit

  // a request is new while no ack stands; writes land at the ack edge
  assign req       = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr        = ack_reg && wb_cyc_i && wb_stb_i && wb_we_i;
  assign wr_lo     = wr && wb_sel_i[0];
  assign wr_mode   = wr_lo && hit(wb_adr_i, adc_seq_pkg::ADDR_MODE);
  assign wr_chan   = wr_lo && hit(wb_adr_i, adc_seq_pkg::ADDR_CHAN);
  assign wr_pf     = wr_lo && (hit(wb_adr_i, adc_seq_pkg::ADDR_PFM) ||
                               hit(wb_adr_i, adc_seq_pkg::ADDR_PFT));
  assign rd_result = req && !wb_we_i && hit(wb_adr_i, adc_seq_pkg::ADDR_RESULT);

  // bus handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= req;
    end
  end

  // read data is captured at the request edge, before any store lands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_reg <= 32'h0;
    end else if (req && !wb_we_i) begin
      if (hit(wb_adr_i, adc_seq_pkg::ADDR_MODE)) begin
        dat_reg <= {24'h0, mode_reg};
      end else if (hit(wb_adr_i, adc_seq_pkg::ADDR_CHAN)) begin
        dat_reg <= {30'h0, chan_reg};
      end else if (hit(wb_adr_i, adc_seq_pkg::ADDR_RESULT)) begin
        dat_reg <= {{(32-RES_W){1'b0}}, result_reg};
      end else if (hit(wb_adr_i, adc_seq_pkg::ADDR_PFM)) begin
        dat_reg <= {24'h0, pfm_reg};
      end else if (hit(wb_adr_i, adc_seq_pkg::ADDR_PFT)) begin
        dat_reg <= {24'h0, pft_reg};
      end else if (hit(wb_adr_i, adc_seq_pkg::ADDR_ISTAT)) begin
        dat_reg <= {22'h0, tif.sampling, tif.busy, 7'h0, flag_reg};
      end else if (hit(wb_adr_i, adc_seq_pkg::ADDR_IMASK)) begin
        dat_reg <= {31'h0, mask_reg};
      end else begin
        dat_reg <= 32'h0; // unmapped reads zero and still acks
      end
    end
  end

  // control registers; only byte lane zero carries writable fields
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= adc_seq_pkg::MODE_RST;
      chan_reg <= adc_seq_pkg::CHAN_RST;
      pfm_reg  <= adc_seq_pkg::PFM_RST;
      pft_reg  <= adc_seq_pkg::PFT_RST;
      mask_reg <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_reg <= wb_dat_i[7:0] & adc_seq_pkg::MODE_WMASK;
      end
      if (wr_chan) begin
        chan_reg <= wb_dat_i[1:0];
      end
      if (wr_lo && hit(wb_adr_i, adc_seq_pkg::ADDR_PFM)) begin
        pfm_reg <= wb_dat_i[7:0] & adc_seq_pkg::PFM_WMASK;
      end
      if (wr_lo && hit(wb_adr_i, adc_seq_pkg::ADDR_PFT)) begin
        pft_reg <= wb_dat_i[7:0];
      end
      if (wr_lo && hit(wb_adr_i, adc_seq_pkg::ADDR_IMASK)) begin
        mask_reg <= wb_dat_i[adc_seq_pkg::FLAG_BIT];
      end
    end
  end

  // a mode, channel or power-fail write restarts a running conversion one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr4_q_reg <= 1'b0;
    end else begin
      wr4_q_reg <= wr_mode || wr_chan || wr_pf;
    end
  end

  // run needs start, power-on, no standby and a legal time code
  assign tif.run = mode_reg[adc_seq_pkg::START_BIT] &&
                   mode_reg[adc_seq_pkg::PWR_BIT] && !standby_i &&
                   adc_seq_pkg::code_ok(tif.code);
  assign tif.restart = wr4_q_reg;
  assign tif.code    = mode_reg[adc_seq_pkg::TSEL_LSB +: 3];

  conv_timer u_timer (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .t     (tif)
  );

  // a colliding mode or channel write wins; the old result is then stale
  assign supp    = wr_mode || wr_chan || wr4_q_reg;
  assign store    = tif.done && !supp;
  assign clr_flag = wr_lo && hit(wb_adr_i, adc_seq_pkg::ADDR_ISTAT) &&
                    wb_dat_i[adc_seq_pkg::FLAG_BIT];

  // the compare uses the fresh sample, so it is taken from the data input
  logic [7:0] new_top;
  logic       pf_new;
  assign new_top  = conv_data_i[RES_W-1 -: 8];
  assign pf_new   = !pfm_reg[adc_seq_pkg::PF_EN_BIT] ||
                    (pfm_reg[adc_seq_pkg::PF_CMP_BIT] ? (new_top < pft_reg) :
                                                        (new_top >= pft_reg));
  assign set_flag = store && pf_new;

  // result store
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_reg <= '0;
    end else if (store) begin
      result_reg <= conv_data_i;
    end
  end

  // sticky flag: set wins over a write-one clear; channel writes leave it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_reg <= 1'b0;
    end else if (set_flag) begin
      flag_reg <= 1'b1;
    end else if (clr_flag) begin
      flag_reg <= 1'b0;
    end
  end

  // level interrupt, registered
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= flag_reg && mask_reg;
    end
  end

  assign wb_ack_o    = ack_reg;
  assign wb_dat_o    = dat_reg;
  assign irq_o       = irq_reg;
  assign channel_o   = chan_reg;
  assign analog_en_o = mode_reg[adc_seq_pkg::PWR_BIT];
  assign sample_o    = tif.sampling;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_stop_write;
    wr_mode && !wb_dat_i[adc_seq_pkg::START_BIT];
  endsequence

  sequence s_idle_after;
    ##2 !tif.busy && !sample_o;
  endsequence

  a_read_first: assert property (
    (rd_result && store) |=> wb_dat_o[RES_W-1:0] == $past(result_reg))
    else $error("read did not see the old result");

  a_write_wins: assert property (
    (tif.done && (wr_mode || wr_chan)) |=> $stable(result_reg))
    else $error("result stored despite a control write");

  a_write_noflag: assert property (
    (tif.done && (wr_mode || wr_chan) && !flag_reg) |=> !flag_reg)
    else $error("flag raised despite a control write");

  a_chan_keeps: assert property (
    (wr_chan && flag_reg && !clr_flag) |=> flag_reg)
    else $error("channel write cleared the flag");

  a_stop_now: assert property (s_stop_write |-> s_idle_after)
    else $error("conversion kept running after stop");

  a_standby_halt: assert property (
    standby_i [*2] |-> !tif.busy)
    else $error("conversion ran in standby");

  a_store_data: assert property (
    store |=> result_reg == $past(conv_data_i))
    else $error("result not stored at done");

  a_pf_gate: assert property (
    (store && !pf_new && !flag_reg) |=> !flag_reg)
    else $error("flag raised although compare failed");

  a_irq_level: assert property (
    ##1 irq_o == $past(flag_reg && mask_reg))
    else $error("interrupt does not follow flag and mask");

  a_restart_delay: assert property (
    (wr_chan && tif.run && mode_reg == $past(mode_reg, 1)) |=> ##1 !sample_o [*8])
    else $error("restart did not hold off sampling");

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood for more than one cycle");

  a_flag_sets: assert property (set_flag |=> flag_reg)
    else $error("flag not set at conversion end");
endmodule : adc_conversion_sequencing

// >>> dv/adc_conversion_sequencing_tb.sv
// Purpose: self-checking bench for the converter sequencing block
// Assumes: one clk_i period is one oscillator period; ack comes one cycle after request
// Notes: conversion end is seen as the next rise of sample_o in continuous mode
`timescale 1ns/1ns
module adc_conversion_sequencing_tb;
  localparam int RES_W = 10;
  localparam int NCODE = 6;
  localparam logic [2:0] CODES [NCODE] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  localparam int CONV [NCODE] = '{288, 240, 192, 144, 120, 96};
  localparam int SAMP [NCODE] = '{40, 32, 24, 20, 16, 12};
  localparam int DMIN [NCODE] = '{32, 28, 24, 16, 14, 12};
  localparam int DMAX [NCODE] = '{36, 32, 28, 18, 16, 14};

  logic             clk_i       = 1'b0;
  logic             rst_i       = 1'b1;
  logic             wb_cyc_i    = 1'b0;
  logic             wb_stb_i    = 1'b0;
  logic             wb_we_i     = 1'b0;
  logic [7:0]       wb_adr_i    = 8'h00;
  logic [3:0]       wb_sel_i    = 4'h0;
  logic [31:0]      wb_dat_i    = 32'h0;
  logic [31:0]      wb_dat_o;
  logic             wb_ack_o;
  logic             standby_i   = 1'b0;
  logic [RES_W-1:0] conv_data_i = 10'h000;
  logic [1:0]       channel_o;
  logic             analog_en_o;
  logic             sample_o;
  logic             irq_o;
  int               n_errors    = 0;
  int               cmp_count   = 0;

`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end

  // 20 MHz clock
  always #25 clk_i = ~clk_i;

  adc_conversion_sequencing #(.RES_W(RES_W)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .standby_i(standby_i),
    .conv_data_i(conv_data_i), .channel_o(channel_o), .analog_en_o(analog_en_o),
    .sample_o(sample_o), .irq_o(irq_o));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : end_sim

  task automatic hang(input string nm);
    n_errors++;
    $display("[ERR] %s exp done got timeout", nm);
    end_sim();
  endtask : hang

  // one classic cycle; signals sampled at the edge see the pre-edge values
  task automatic wb_acc(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                        output logic [31:0] rd);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    for (n = 0; n < 20; n++) begin
      @(posedge clk_i);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n == 20) hang("wb ack");
  endtask : wb_acc

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
    logic [31:0] d;
    wb_acc(1'b1, adr, dat, d);
  endtask : wr

  task automatic rd(input logic [7:0] adr, output logic [31:0] d);
    wb_acc(1'b0, adr, 32'h0, d);
  endtask : rd

  // counts edges until sample_o shows lvl; n equals max when it never does
  task automatic wait_samp(input logic lvl, input int max, input bit must, output int n);
    for (n = 0; n < max; n++) begin
      @(posedge clk_i);
      if (sample_o === lvl) break;
    end
    n = n + 1;
    if (n > max) n = max;
    if (must && n == max && sample_o !== lvl) hang("sample edge");
  endtask : wait_samp

  function automatic logic [31:0] start_word(input logic [2:0] code);
    start_word = {24'h0, 1'b1, 1'b0, code, 2'b00, 1'b1};
  endfunction : start_word

  // stop converting, then clear the flag so a resumed run starts clean
  task automatic stop_clear;
    wr(adc_seq_pkg::ADDR_MODE, 32'h01);
    repeat (4) @(posedge clk_i);
    wr(adc_seq_pkg::ADDR_ISTAT, 32'h01);
  endtask : stop_clear

  task automatic t_reset;
    logic [7:0] adrs [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    logic [31:0] d;
    `CHK("outputs", 5'h00, {channel_o, analog_en_o, sample_o, irq_o})
    foreach (adrs[i]) begin
      rd(adrs[i], d);
      `CHK("reset value", 32'h0, d)
    end
    wr(8'h1c, 32'hffff_ffff);
    rd(8'h1c, d);
    `CHK("unmapped", 32'h0, d)
    $display("test reset done");
  endtask : t_reset

  // delay, sampling window and conversion period for every legal code
  task automatic t_timing;
    int dly;
    int len;
    int low;
    wr(adc_seq_pkg::ADDR_MODE, 32'h01);
    repeat (290) @(posedge clk_i);
    // only the register bus moves while converting, never conv_data_i or standby_i
    for (int i = 0; i < NCODE; i++) begin
      wr(adc_seq_pkg::ADDR_MODE, start_word(CODES[i]));
      wait_samp(1'b1, 80, 1'b1, dly);
      `CHK("start delay", 1'b1, (dly >= DMIN[i] && dly <= DMAX[i] + 3))
      wait_samp(1'b0, 80, 1'b1, len);
      wait_samp(1'b1, 400, 1'b1, low);
      `CHK("sample len", SAMP[i], len)
      `CHK("conv time", CONV[i], len + low)
      stop_clear();
    end
    wr(adc_seq_pkg::ADDR_MODE, start_word(3'h3));
    wait_samp(1'b1, 400, 1'b0, dly);
    `CHK("barred code idles", 400, dly)
    stop_clear();
    $display("test timing done");
  endtask : t_timing

  task automatic t_result_irq;
    logic [31:0] d;
    int n;
    conv_data_i <= 10'h2a5;
    wr(adc_seq_pkg::ADDR_MODE, start_word(3'h6));
    wait_samp(1'b1, 80, 1'b1, n);
    wait_samp(1'b0, 80, 1'b1, n);
    wait_samp(1'b1, 200, 1'b1, n);
    repeat (3) @(posedge clk_i);
    rd(adc_seq_pkg::ADDR_RESULT, d);
    `CHK("result", 32'h2a5, d)
    wr(adc_seq_pkg::ADDR_MODE, 32'h01);
    repeat (4) @(posedge clk_i);
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("flag set", 32'h1, d)
    `CHK("irq masked", 1'b0, irq_o)
    wr(adc_seq_pkg::ADDR_IMASK, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK("irq raised", 1'b1, irq_o)
    wr(adc_seq_pkg::ADDR_CHAN, 32'h3);
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("flag kept", 1'b1, d[0])
    `CHK("channel", 2'h3, channel_o)
    wr(adc_seq_pkg::ADDR_ISTAT, 32'h1);
    repeat (2) @(posedge clk_i);
    `CHK("irq cleared", 1'b0, irq_o)
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("flag cleared", 32'h0, d)
    $display("test result_irq done");
  endtask : t_result_irq

  // a channel write mid-conversion starts over, so the old finish never shows
  task automatic t_restart;
    logic [31:0] d;
    int n;
    wr(adc_seq_pkg::ADDR_MODE, start_word(3'h6));
    wait_samp(1'b1, 80, 1'b1, n);
    repeat (50) @(posedge clk_i);
    wr(adc_seq_pkg::ADDR_CHAN, 32'h1);
    wait_samp(1'b1, 30, 1'b1, n);
    `CHK("restart delay", 1'b1, (n >= 12 && n <= 17))
    wait_samp(1'b0, 80, 1'b1, n);
    repeat (25) @(posedge clk_i); // past the edge the old conversion would end
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("no old finish", 1'b0, d[0])
    wait_samp(1'b1, 200, 1'b1, n);
    repeat (3) @(posedge clk_i);
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("new finish", 1'b1, d[0])
    stop_clear();
    $display("test restart done");
  endtask : t_restart

  task automatic t_stop;
    logic [31:0] d;
    int n;
    wr(adc_seq_pkg::ADDR_MODE, start_word(3'h0));
    wait_samp(1'b1, 80, 1'b1, n);
    repeat (20) @(posedge clk_i);
    wr(adc_seq_pkg::ADDR_MODE, 32'h01);
    repeat (3) @(posedge clk_i);
    `CHK("sample off", 1'b0, sample_o)
    wait_samp(1'b1, 400, 1'b0, n);
    `CHK("stays idle", 400, n)
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("no flag", 32'h0, d)
    wr(adc_seq_pkg::ADDR_ISTAT, 32'h1);
    wr(adc_seq_pkg::ADDR_MODE, start_word(3'h6));
    wait_samp(1'b1, 80, 1'b1, n);
    standby_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    wait_samp(1'b1, 300, 1'b0, n);
    `CHK("standby halts", 300, n)
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("standby no flag", 32'h0, d)
    wr(adc_seq_pkg::ADDR_MODE, 32'h00);
    standby_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    `CHK("power off", 2'b00, {analog_en_o, sample_o})
    wr(adc_seq_pkg::ADDR_ISTAT, 32'h1);
    $display("test stop done");
  endtask : t_stop

  // power-fail gating: both compare senses, result stored either way
  task automatic t_pfail;
    logic [7:0] power_fail_mode_register [3] = '{8'h80, 8'h80, 8'hc0};
    logic [9:0] dat [3] = '{10'h2a5, 10'h200, 10'h200};
    logic       exp [3] = '{1'b1, 1'b0, 1'b1};
    logic [31:0] d;
    int n;
    wr(adc_seq_pkg::ADDR_MODE, 32'h01);
    repeat (290) @(posedge clk_i);
    wr(adc_seq_pkg::ADDR_PFT, 32'ha0);
    for (int i = 0; i < 3; i++) begin
      conv_data_i <= dat[i];
      wr(adc_seq_pkg::ADDR_PFM, {24'h0, power_fail_mode_register[i]});
      wr(adc_seq_pkg::ADDR_MODE, start_word(3'h6));
      wait_samp(1'b1, 80, 1'b1, n);
      wait_samp(1'b0, 80, 1'b1, n);
      wait_samp(1'b1, 200, 1'b1, n);
      repeat (3) @(posedge clk_i);
      rd(adc_seq_pkg::ADDR_RESULT, d);
      `CHK("pf result", {22'h0, dat[i]}, d)
      rd(adc_seq_pkg::ADDR_ISTAT, d);
      `CHK("pf flag", exp[i], d[0])
      stop_clear();
    end
    wr(adc_seq_pkg::ADDR_PFM, 32'h0);
    $display("test pfail done");
  endtask : t_pfail

  // a result read, then a channel write, each landing on a result store
  task automatic t_collide;
    logic [31:0] d;
    int n;
    conv_data_i <= 10'h155;
    wr(adc_seq_pkg::ADDR_MODE, start_word(3'h6));
    wait_samp(1'b1, 80, 1'b1, n);
    wait_samp(1'b0, 80, 1'b1, n);
    wait_samp(1'b1, 200, 1'b1, n);
    conv_data_i <= 10'h0aa;
    wait_samp(1'b0, 80, 1'b1, n);
    repeat (82) @(posedge clk_i); // read is taken at the store edge
    rd(adc_seq_pkg::ADDR_RESULT, d);
    `CHK("read before store", 32'h155, d)
    rd(adc_seq_pkg::ADDR_RESULT, d);
    `CHK("store after read", 32'h0aa, d)
    conv_data_i <= 10'h3c3;
    wr(adc_seq_pkg::ADDR_ISTAT, 32'h1);
    wait_samp(1'b0, 80, 1'b1, n);
    repeat (81) @(posedge clk_i); // write lands at the store edge
    wr(adc_seq_pkg::ADDR_CHAN, 32'h2);
    rd(adc_seq_pkg::ADDR_RESULT, d);
    `CHK("write wins result", 32'h0aa, d)
    rd(adc_seq_pkg::ADDR_ISTAT, d);
    `CHK("write wins flag", 1'b0, d[0])
    stop_clear();
    $display("test collide done");
  endtask : t_collide

  // reset held for eight cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_timing();
    t_result_irq();
    t_restart();
    t_stop();
    t_pfail();
    t_collide();
    end_sim();
  end
endmodule : adc_conversion_sequencing_tb
